// ---- dv/sscmd_asserts.sv ----
// Checker for the command handler: bus response, group output and reply fields.
// Assumes one AHB-Lite master doing single word transfers; bound to sscmd_top.
`timescale 1ns/1ps
module sscmd_asserts (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_o,
  input  wire logic        hreadyout_o,
  input  wire logic        hresp_o,
  input  wire logic [7:0]  group_o
);
  logic        dp_wr;
  logic        dp_rd;
  logic        bad_q;
  logic [31:0] dp_a;
  logic [31:0] cmd_q;
  logic [31:0] wd_q;

  function automatic logic at(input logic [7:0] o);
    return dp_a == {24'h0, o};
  endfunction

  wire         tk  = hsel_i && hready_i && htrans_i[1] && hsize_i == sscmd_pkg::HSIZE_WORD;
  wire         go  = dp_wr && at(sscmd_pkg::OFS_CTRL) && hwdata_i[sscmd_pkg::CTRL_GO];
  wire [7:0]   c   = cmd_q[7:0];
  wire         tc  = c == sscmd_pkg::CMD_PT_ACC || c == sscmd_pkg::CMD_PT_DEC || c == sscmd_pkg::CMD_PT_DWELL;
  // Tracked refusals follow from the command and write data words alone; those that depend on hidden state are not tracked.
  wire         bad = tc && wd_q > sscmd_pkg::TIME_MAX || c == sscmd_pkg::CMD_PT_AUX && wd_q > sscmd_pkg::AUX_MAX
                     || c == sscmd_pkg::CMD_GROUP_WR && cmd_q[15:8] != sscmd_pkg::DNUM_ZERO;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      bad_q <= 1'b0;
      dp_a  <= 32'h0;
      cmd_q <= 32'h0;
      wd_q  <= 32'h0;
    end else begin
      dp_wr <= tk && hwrite_i;
      dp_rd <= tk && !hwrite_i;
      if (tk) dp_a <= haddr_i;
      if (dp_wr && at(sscmd_pkg::OFS_CMD)) cmd_q <= hwdata_i;
      if (dp_wr && at(sscmd_pkg::OFS_WDATA)) wd_q <= hwdata_i;
      if (go) bad_q <= bad;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  bus_okay_a: assert property (hreadyout_o && hresp_o == sscmd_pkg::HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  group_range_a: assert property (group_o == 8'h00 || group_o inside {[8'h61:8'h66]})
    else $error("group output outside a to f");
  group_cause_a: assert property ($changed(group_o) |-> $past(go, 2))
    else $error("group output changed without a command");
  group_reg_a: assert property (dp_rd && at(sscmd_pkg::OFS_GROUP) |-> hrdata_o == {24'h0, $past(group_o)})
    else $error("group register differs from group output");
  point_pos_a: assert property (dp_rd && at(sscmd_pkg::OFS_RINFO) |-> hrdata_o[6:4] <= 3'h5)
    else $error("reply point position above five");
  info_spare_a: assert property (dp_rd && at(sscmd_pkg::OFS_RINFO) |-> hrdata_o[31:9] == 23'h0
    && hrdata_o[3:1] == 3'h0 && !hrdata_o[7])
    else $error("reply information spare bits set");
  refuse_err_a: assert property (dp_rd && at(sscmd_pkg::OFS_STATUS) && hrdata_o[1] && bad_q |-> hrdata_o[2])
    else $error("out of range command not refused");
  unmapped_zero_a: assert property (dp_rd && dp_a > 32'h18 |-> hrdata_o == 32'h0)
    else $error("unmapped read not zero");

  cover property (go);
  cover property (dp_rd && at(sscmd_pkg::OFS_STATUS) && hrdata_o[2]);
  cover property ($changed(group_o));
endmodule

bind sscmd_top sscmd_asserts u_chk (.ref_clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
  .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .group_o);

// ---- dv/sscmd_host.sv ----
// Master station model: single word AHB-Lite transfers and command sequences.
// Assumes it is the only master and that hready comes from the one slave.
`timescale 1ns/1ps
module sscmd_host (
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = sscmd_pkg::HSIZE_WORD;
    hwdata_o = 32'h0;
  end

  // Called just after a rising edge; released address and write data lines show the inverse so stale data cannot pass.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    hsel_o <= 1'b1;
    haddr_o <= {24'h0, a};
    htrans_o <= 2'h2;
    hwrite_o <= w;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    haddr_o <= ~haddr_o;
    hwdata_o <= w ? d : ~hwdata_o;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    q = hrdata_i;
    hwdata_o <= ~d;
  endtask

  task automatic run(input logic [7:0] c, input logic [7:0] n, input logic [31:0] w, output logic [31:0] st);
    logic [31:0] q;
    xfer(sscmd_pkg::OFS_CMD, 1'b1, {16'h0, n, c}, q);
    xfer(sscmd_pkg::OFS_WDATA, 1'b1, w, q);
    xfer(sscmd_pkg::OFS_CTRL, 1'b1, 32'h1, q);
    st = 32'h1;
    for (int k = 0; k < 8 && st[sscmd_pkg::ST_BUSY] !== 1'b0; k++) xfer(sscmd_pkg::OFS_STATUS, 1'b0, 32'h0, st);
  endtask

  task automatic rep(output logic [31:0] d, output logic [31:0] i);
    xfer(sscmd_pkg::OFS_RDATA, 1'b0, 32'h0, d);
    xfer(sscmd_pkg::OFS_RINFO, 1'b0, 32'h0, i);
  endtask

  function automatic logic [31:0] pword(input logic [3:0] dp, input logic [3:0] m, input logic [23:0] v,
                                        input logic hex);
    return {hex ? sscmd_pkg::DP_NONE : dp, m, v};
  endfunction

  // Type 0 is shown in decimal with the point placed, type 1 as is; the binary word is the same.
  function automatic logic [31:0] keep(input logic [31:0] d, input logic [31:0] i);
    return i[sscmd_pkg::RI_RDEN] ? d : 32'h0;
  endfunction
endmodule

// ---- dv/tb.sv ----
// Bench for the command handler: commands, refusals and replies through the master model.
// Assumes the checker is bound to sscmd_top and that parameter 7 is the only hex parameter.
`timescale 1ns/1ps
module tb;
  logic        ref_clk_i  = 1'b0;
  logic        resetn_i   = 1'b0;
  logic [31:0] in_dev_i   = 32'h0;
  logic        fb_pulse_i = 1'b0;
  logic        fb_dir_i   = 1'b0;
  logic        hsel_i, hwrite_i, hreadyout_o, hresp_o, b, u;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, st, d, inf, cnt, w, lim;
  logic [7:0]  group_o, n, g;
  logic [7:0]  pc [4] = '{sscmd_pkg::CMD_PT_ACC, sscmd_pkg::CMD_PT_DEC, sscmd_pkg::CMD_PT_DWELL, sscmd_pkg::CMD_PT_AUX};
  logic [31:0] gv [6] = '{32'h60, 32'h61, 32'h66, 32'h67, 32'h162, 32'h64};
  logic [7:0]  bh [4] = '{8'h03, 8'h63, 8'h21, 8'h24};
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  sscmd_host host (.clk_i(ref_clk_i), .hready_i(hreadyout_o), .hrdata_i(hrdata_o), .hsel_o(hsel_i),
    .haddr_o(haddr_i), .htrans_o(htrans_i), .hwrite_o(hwrite_i), .hsize_o(hsize_i), .hwdata_o(hwdata_i));
  sscmd_top #(.PARAM_HEX_MASK(64'h80)) uut (.ref_clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .in_dev_i, .fb_pulse_i, .fb_dir_i, .hrdata_o, .hreadyout_o,
    .hresp_o, .group_o);

  always #20 ref_clk_i = ~ref_clk_i;

  task automatic close_out;
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic go(input logic [7:0] c, input logic [7:0] nn, input logic [31:0] ww, input logic e);
    host.run(c, nn, ww, st);
    cmp("done", 32'h1, {31'h0, st[sscmd_pkg::ST_DONE]});
    cmp("err", {31'h0, e}, {31'h0, st[sscmd_pkg::ST_ERR]});
  endtask

  task automatic ask(input logic [7:0] c, input logic [7:0] nn);
    go(c, nn, 32'h0, 1'b0);
    host.rep(d, inf);
  endtask

  function automatic logic pt_bad(input logic [7:0] c, input logic [7:0] nn, input logic [31:0] ww);
    return nn == 8'h00 || nn > 8'h0F || ww > (c == sscmd_pkg::CMD_PT_AUX ? sscmd_pkg::AUX_MAX : sscmd_pkg::TIME_MAX);
  endfunction

  initial begin
    w = $urandom(32'hCD28);
    cnt = 32'h0;
    g = sscmd_pkg::GROUP_RESET;
    gv[5] = 32'($urandom_range(32'h66, 32'h61));
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    cmp("group", 32'h0, {24'h0, group_o});
    host.xfer(8'h1C, 1'b0, 32'h0, d);
    cmp("unmapped", 32'h0, d);
    foreach (pc[i]) begin
      for (int k = 0; k < 6; k++) begin
        lim = pc[i] == sscmd_pkg::CMD_PT_AUX ? sscmd_pkg::AUX_MAX : sscmd_pkg::TIME_MAX;
        n = k == 0 ? 8'h00 : k == 1 ? 8'h10 : k == 2 ? 8'h0F : 8'($urandom_range(15, 1));
        w = k == 2 ? lim : k == 3 ? lim + 32'h1 : 32'($urandom_range(2 * lim));
        go(pc[i], n, w, pt_bad(pc[i], n, w));
      end
    end
    foreach (gv[k]) begin
      b = gv[k] >= 32'h61 && gv[k] <= 32'h66;
      go(sscmd_pkg::CMD_GROUP_WR, 8'h00, gv[k], !b);
      if (b) g = gv[k][7:0];
      cmp("group", {24'h0, g}, {24'h0, group_o});
    end
    go(sscmd_pkg::CMD_GROUP_WR, 8'h01, 32'h63, 1'b1);
    host.xfer(sscmd_pkg::OFS_GROUP, 1'b0, 32'h0, d);
    cmp("group_reg", {24'h0, g}, d);
    host.hsize_o <= 3'h0;
    host.xfer(sscmd_pkg::OFS_GROUP, 1'b0, 32'h0, d);
    cmp("byte_read", 32'h0, d);
    host.xfer(sscmd_pkg::OFS_WDATA, 1'b1, 32'hFFFF_FFFF, d);
    host.hsize_o <= sscmd_pkg::HSIZE_WORD;
    host.xfer(sscmd_pkg::OFS_WDATA, 1'b0, 32'h0, d);
    cmp("byte_write", 32'h63, d);
    w = 32'($urandom_range(32'hFFFFFF));
    go(sscmd_pkg::CMD_PAR_WR, 8'h03, {8'h23, w[23:0]}, 1'b0);
    ask(sscmd_pkg::CMD_PAR_RD, 8'h03);
    cmp("param", {8'h0, w[23:0]}, d);
    cmp("info", 32'h120, inf);
    foreach (bh[k]) go(sscmd_pkg::CMD_PAR_WR, 8'h03, {bh[k], 24'h5A5A5A}, 1'b1);
    ask(sscmd_pkg::CMD_PAR_RD, 8'h03);
    cmp("param", {8'h0, w[23:0]}, d);
    go(sscmd_pkg::CMD_PAR_WR, 8'h35, {8'h50, 24'h1}, 1'b0);
    ask(sscmd_pkg::CMD_PAR_RD, 8'h35);
    cmp("info", 32'h150, inf);
    go(sscmd_pkg::CMD_PAR_RD, 8'h36, 32'h0, 1'b1);
    go(sscmd_pkg::CMD_PAR_WR, 8'h07, host.pword(4'h3, sscmd_pkg::MODE_RAM, 24'hABCDEF, 1'b1), 1'b0);
    go(sscmd_pkg::CMD_PAR_WR, 8'h07, {8'h13, 24'h1}, 1'b1);
    ask(sscmd_pkg::CMD_PAR_RD, 8'h07);
    cmp("param", 32'hABCDEF, d);
    cmp("info", 32'h101, inf);
    go(sscmd_pkg::CMD_PAR_WR, 8'h13, {8'h13, 24'h3}, 1'b0);
    ask(sscmd_pkg::CMD_PAR_RD, 8'h03);
    cmp("rden", 32'h0, {31'h0, inf[sscmd_pkg::RI_RDEN]});
    cmp("param", 32'h0, host.keep(d, inf));
    go(sscmd_pkg::CMD_PAR_WR, 8'h03, {8'h23, 24'h1}, 1'b1);
    go(sscmd_pkg::CMD_PAR_WR, 8'h13, {8'h13, 24'h0}, 1'b0);
    repeat (40) begin
      b = 1'($urandom_range(1));
      u = cnt != 32'h0 && $urandom_range(1) != 0;
      fb_pulse_i <= b;
      fb_dir_i <= u;
      if (b) cnt = u ? cnt - 32'h1 : cnt + 32'h1;
      @(posedge ref_clk_i);
    end
    fb_pulse_i <= 1'b0;
    ask(sscmd_pkg::CMD_STAT_RD, sscmd_pkg::ITEM_CUM_FB);
    cmp("count", cnt, d);
    cmp("info", 32'h100, inf);
    go(sscmd_pkg::CMD_STAT_CLR, 8'h00, 32'h1EA5, 1'b0);
    ask(sscmd_pkg::CMD_STAT_RD, sscmd_pkg::ITEM_CUM_FB);
    cmp("count", 32'h0, d);
    go(sscmd_pkg::CMD_STAT_CLR, 8'h01, 32'h1EA5, 1'b1);
    go(sscmd_pkg::CMD_STAT_CLR, 8'h00, 32'h1EA4, 1'b1);
    go(sscmd_pkg::CMD_STAT_RD, 8'h81, 32'h0, 1'b1);
    in_dev_i <= $urandom();
    ask(sscmd_pkg::CMD_IN_RD, 8'h00);
    cmp("inputs", in_dev_i, d);
    cmp("disp", 32'h1, {31'h0, inf[sscmd_pkg::RI_DISP]});
    in_dev_i <= 32'h1;
    ask(sscmd_pkg::CMD_IN_RD, 8'h00);
    cmp("servo_on", 32'h1, d);
    go(sscmd_pkg::CMD_IN_RD, 8'h01, 32'h0, 1'b1);
    go(8'h40, 8'h00, 32'h0, 1'b1);
    close_out();
  end
endmodule

// ---- hdl/sscmd_pkg.sv ----
// Constants shared by the servo station command handler and its write-header checker.
// Assumes byte addresses on a 32-bit AHB-Lite bus and command codes in two hex characters.
// How it works
// - Acceleration write to points 01..0F, 0..20000.
// - Deceleration write to points 01..0F, 0..20000.
// - Dwell write to points 01..0F, 0..20000.
// - Auxiliary write to points 01..0F, 0 or 1.
// - Group write, number 00, value a..f.
// - Decimal data needs point position; hex uses 0.
// - Status read returns value plus processing information.
// - Clear with key 1EA5 zeroes cumulative feedback.
// - Parameter read for numbers 00..35 hex.
// - Reply carries read enable from parameter 19.
// - Parameter write selects parameter by data number.
// - Point code 0 none, 1..5 lower digits.
// - Mode 0 stores nonvolatile, mode 3 RAM only.
// - Input device read, data number 00.
// - Input bits one per device, bit 0 servo-on.
package sscmd_pkg;
  localparam logic [7:0]  OFS_CMD      = 8'h00;
  localparam logic [7:0]  OFS_WDATA    = 8'h04;
  localparam logic [7:0]  OFS_CTRL     = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0C;
  localparam logic [7:0]  OFS_RDATA    = 8'h10;
  localparam logic [7:0]  OFS_RINFO    = 8'h14;
  localparam logic [7:0]  OFS_GROUP    = 8'h18;
  localparam logic [7:0]  OFS_NONE     = 8'hFF;

  localparam logic [7:0]  CMD_STAT_RD  = 8'h01;
  localparam logic [7:0]  CMD_PAR_RD   = 8'h05;
  localparam logic [7:0]  CMD_IN_RD    = 8'h12;
  localparam logic [7:0]  CMD_STAT_CLR = 8'h81;
  localparam logic [7:0]  CMD_PAR_WR   = 8'h84;
  localparam logic [7:0]  CMD_GROUP_WR = 8'h9F;
  localparam logic [7:0]  CMD_PT_ACC   = 8'hC7;
  localparam logic [7:0]  CMD_PT_DEC   = 8'hC8;
  localparam logic [7:0]  CMD_PT_DWELL = 8'hCA;
  localparam logic [7:0]  CMD_PT_AUX   = 8'hCB;

  localparam logic [7:0]  DNUM_ZERO    = 8'h00;
  localparam logic [7:0]  DNUM_PT_MIN  = 8'h01;
  localparam logic [7:0]  ITEM_CUM_FB  = 8'h80;
  localparam logic [15:0] CLEAR_KEY    = 16'h1EA5;
  localparam logic [31:0] TIME_MAX     = 32'h0000_4E20;
  localparam logic [31:0] AUX_MAX      = 32'h0000_0001;
  localparam logic [7:0]  GROUP_MIN    = 8'h61;
  localparam logic [7:0]  GROUP_MAX    = 8'h66;
  localparam logic [7:0]  GROUP_RESET  = 8'h00;
  localparam logic [5:0]  PAR_INHIBIT  = 6'h13;
  localparam int          INH_WR_BIT   = 0;
  localparam int          INH_RD_BIT   = 1;

  localparam int          DP_MSB       = 31;
  localparam int          DP_LSB       = 28;
  localparam int          MODE_MSB     = 27;
  localparam int          MODE_LSB     = 24;
  localparam int          VAL_MSB      = 23;
  localparam logic [3:0]  DP_NONE      = 4'h0;
  localparam logic [3:0]  DP_MAX       = 4'h5;
  localparam logic [3:0]  MODE_EEP     = 4'h0;
  localparam logic [3:0]  MODE_RAM     = 4'h3;
  localparam logic        DISP_DEC     = 1'b0;
  localparam logic        DISP_HEX     = 1'b1;

  localparam int          CTRL_GO      = 0;
  localparam int          ST_BUSY      = 0;
  localparam int          ST_DONE      = 1;
  localparam int          ST_ERR       = 2;
  localparam int          RI_DISP      = 0;
  localparam int          RI_DP_LSB    = 4;
  localparam int          RI_DP_MSB    = 6;
  localparam int          RI_RDEN      = 8;
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;
  localparam logic        HRESP_OKAY   = 1'b0;

  typedef enum logic [0:0] {
    SSCMD_IDLE = 1'b0,
    SSCMD_EXEC = 1'b1
  } sscmd_state_t;
endpackage

// ---- hdl/sscmd_top.sv ----
// Servo station command handler: AHB-Lite register front end and one-cycle command execution.
// Assumes a single AHB-Lite master doing word transfers, with all inputs synchronous to ref_clk_i.
`timescale 1ns/1ps
module sscmd_top #(
  parameter int unsigned  NUM_POINTS     = 15,
  parameter int unsigned  NUM_PARAMS     = 54,
  parameter logic [63:0]  PARAM_HEX_MASK = 64'h0,
  parameter logic [23:0]  PARAM_RESET    = 24'h0
) (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] in_dev_i,
  input  wire logic        fb_pulse_i,
  input  wire logic        fb_dir_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [7:0]       group_o
);
  if (NUM_POINTS < 1 || NUM_POINTS > 15) begin : g_chk_points
    $error("NUM_POINTS must lie in 1 to 15");
  end
  if (NUM_PARAMS <= 19 || NUM_PARAMS > 64) begin : g_chk_params
    $error("NUM_PARAMS must lie in 20 to 64");
  end

  localparam logic [7:0] PT_LAST  = 8'(NUM_POINTS);
  localparam logic [7:0] PAR_LAST = 8'(NUM_PARAMS - 1);

  typedef struct packed {
    sscmd_pkg::sscmd_state_t fsm;
    logic [7:0]              cmd;
    logic [7:0]              dnum;
    logic [31:0]             wdata;
    logic                    done;
    logic                    err;
    logic [31:0]             rdata;
    logic                    disp;
    logic [2:0]              dp;
    logic                    rden;
    logic [7:0]              group;
    logic [7:0]              last_item;
    logic [31:0]             cum_fb;
    logic                    ph_valid;
    logic                    ph_write;
    logic [7:0]              ph_addr;
    logic [31:0]             hrdata;
    logic                    hready;
    logic                    hresp;
  } sscmd_regs_t;

  sscmd_regs_t r;
  sscmd_regs_t next_r;

  // Point table and parameter storage; the second parameter copy stands for the nonvolatile store.
  logic [15:0] acc_mem   [1:NUM_POINTS];
  logic [15:0] dec_mem   [1:NUM_POINTS];
  logic [15:0] dwell_mem [1:NUM_POINTS];
  logic        aux_mem   [1:NUM_POINTS];
  logic [26:0] par_ram   [0:NUM_PARAMS-1];
  logic [26:0] par_eep   [0:NUM_PARAMS-1];

  logic        acc_we;
  logic        dec_we;
  logic        dwell_we;
  logic        aux_we;
  logic        par_we;
  logic        eep_we;
  logic        clr_fb;
  logic [3:0]  pt_idx;
  logic [5:0]  par_idx;
  logic [26:0] par_word;
  logic        par_hex;
  logic        chk_ok;
  logic        chk_ram_only;
  logic        pt_ok;
  logic        par_ok;
  logic        par_rd_en;
  logic        par_wr_en;
  logic        take;
  logic [31:0] fb_base;

  function automatic logic [7:0] ofs_of(input logic [31:0] a);
    logic [7:0] o;
    o = sscmd_pkg::OFS_NONE;
    if (a[31:8] == 24'h0 && a[1:0] == 2'h0) begin
      o = a[7:0];
    end
    return o;
  endfunction

  function automatic logic [31:0] rd_mux(input logic [7:0] ofs, input sscmd_regs_t s);
    logic [31:0] v;
    v = 32'h0;
    case (ofs)
      sscmd_pkg::OFS_CMD: begin
        v = {16'h0, s.dnum, s.cmd};
      end
      sscmd_pkg::OFS_WDATA: begin
        v = s.wdata;
      end
      sscmd_pkg::OFS_STATUS: begin
        v[sscmd_pkg::ST_BUSY] = (s.fsm == sscmd_pkg::SSCMD_EXEC);
        v[sscmd_pkg::ST_DONE] = s.done;
        v[sscmd_pkg::ST_ERR]  = s.err;
      end
      sscmd_pkg::OFS_RDATA: begin
        v = s.rdata;
      end
      sscmd_pkg::OFS_RINFO: begin
        v[sscmd_pkg::RI_DISP]                         = s.disp;
        v[sscmd_pkg::RI_DP_MSB:sscmd_pkg::RI_DP_LSB] = s.dp;
        v[sscmd_pkg::RI_RDEN]                         = s.rden;
      end
      sscmd_pkg::OFS_GROUP: begin
        v = {24'h0, s.group};
      end
      default: begin
        v = 32'h0;
      end
    endcase
    return v;
  endfunction

  assign pt_idx   = r.dnum[3:0];
  assign par_idx  = r.dnum[5:0];
  assign par_hex  = PARAM_HEX_MASK[par_idx];
  assign pt_ok    = (r.dnum >= sscmd_pkg::DNUM_PT_MIN) && (r.dnum <= PT_LAST);
  assign par_ok   = (r.dnum <= PAR_LAST);
  assign take     = hsel_i && hready_i && htrans_i[1];

  sscmd_wcheck u_wcheck (
    .wdata_i    (r.wdata),
    .is_hex_i   (par_hex),
    .ok_o       (chk_ok),
    .ram_only_o (chk_ram_only),
    .word_o     (par_word)
  );

  // The inhibit parameter itself stays reachable, otherwise a set inhibit could never be undone.
  always_comb begin
    par_rd_en = 1'b1;
    par_wr_en = 1'b1;
    if (par_idx != sscmd_pkg::PAR_INHIBIT) begin
      par_rd_en = !par_ram[sscmd_pkg::PAR_INHIBIT][sscmd_pkg::INH_RD_BIT];
      par_wr_en = !par_ram[sscmd_pkg::PAR_INHIBIT][sscmd_pkg::INH_WR_BIT];
    end
  end

  always_comb begin
    next_r   = r;
    acc_we   = 1'b0;
    dec_we   = 1'b0;
    dwell_we = 1'b0;
    aux_we   = 1'b0;
    par_we   = 1'b0;
    eep_we   = 1'b0;
    clr_fb   = 1'b0;

    // Zero-wait slave: read data is fetched in the address phase so it leaves a flip-flop.
    next_r.hready   = 1'b1;
    next_r.hresp    = sscmd_pkg::HRESP_OKAY;
    next_r.ph_valid = take && (hsize_i == sscmd_pkg::HSIZE_WORD);
    next_r.ph_write = hwrite_i;
    next_r.ph_addr  = ofs_of(haddr_i);
    if (take && !hwrite_i) begin
      next_r.hrdata = (hsize_i == sscmd_pkg::HSIZE_WORD) ? rd_mux(ofs_of(haddr_i), r) : 32'h0;
    end

    if (r.ph_valid && r.ph_write) begin
      case (r.ph_addr)
        sscmd_pkg::OFS_CMD: begin
          next_r.cmd  = hwdata_i[7:0];
          next_r.dnum = hwdata_i[15:8];
        end
        sscmd_pkg::OFS_WDATA: begin
          next_r.wdata = hwdata_i;
        end
        sscmd_pkg::OFS_CTRL: begin
          if (hwdata_i[sscmd_pkg::CTRL_GO] && r.fsm == sscmd_pkg::SSCMD_IDLE) begin
            next_r.fsm  = sscmd_pkg::SSCMD_EXEC;
            next_r.done = 1'b0;
            next_r.err  = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    case (r.fsm)
      sscmd_pkg::SSCMD_EXEC: begin
        next_r.fsm  = sscmd_pkg::SSCMD_IDLE;
        next_r.done = 1'b1;
        case (r.cmd)
          sscmd_pkg::CMD_STAT_RD: begin
            if (r.dnum == sscmd_pkg::ITEM_CUM_FB) begin
              next_r.rdata     = r.cum_fb;
              next_r.disp      = sscmd_pkg::DISP_DEC;
              next_r.dp        = 3'h0;
              next_r.rden      = 1'b1;
              next_r.last_item = r.dnum;
            end else begin
              next_r.err = 1'b1;
            end
          end
          sscmd_pkg::CMD_STAT_CLR: begin
            if (r.dnum == sscmd_pkg::DNUM_ZERO && r.wdata[15:0] == sscmd_pkg::CLEAR_KEY
                && r.last_item == sscmd_pkg::ITEM_CUM_FB) begin
              clr_fb = 1'b1;
            end else begin
              next_r.err = 1'b1;
            end
          end
          sscmd_pkg::CMD_PAR_RD: begin
            if (par_ok) begin
              next_r.rden  = par_rd_en;
              next_r.rdata = par_rd_en ? {8'h0, par_ram[par_idx][23:0]} : 32'h0;
              next_r.dp    = par_ram[par_idx][26:24];
              next_r.disp  = par_hex ? sscmd_pkg::DISP_HEX : sscmd_pkg::DISP_DEC;
            end else begin
              next_r.err = 1'b1;
            end
          end
          sscmd_pkg::CMD_PAR_WR: begin
            if (par_ok && chk_ok && par_wr_en) begin
              par_we = 1'b1;
              eep_we = !chk_ram_only;
            end else begin
              next_r.err = 1'b1;
            end
          end
          sscmd_pkg::CMD_IN_RD: begin
            if (r.dnum == sscmd_pkg::DNUM_ZERO) begin
              next_r.rdata = in_dev_i;
              next_r.disp  = sscmd_pkg::DISP_HEX;
              next_r.dp    = 3'h0;
              next_r.rden  = 1'b1;
            end else begin
              next_r.err = 1'b1;
            end
          end
          sscmd_pkg::CMD_GROUP_WR: begin
            if (r.dnum == sscmd_pkg::DNUM_ZERO && r.wdata[31:8] == 24'h0
                && r.wdata[7:0] >= sscmd_pkg::GROUP_MIN && r.wdata[7:0] <= sscmd_pkg::GROUP_MAX) begin
              next_r.group = r.wdata[7:0];
            end else begin
              next_r.err = 1'b1;
            end
          end
          sscmd_pkg::CMD_PT_ACC: begin
            acc_we     = pt_ok && (r.wdata <= sscmd_pkg::TIME_MAX);
            next_r.err = !acc_we;
          end
          sscmd_pkg::CMD_PT_DEC: begin
            dec_we     = pt_ok && (r.wdata <= sscmd_pkg::TIME_MAX);
            next_r.err = !dec_we;
          end
          sscmd_pkg::CMD_PT_DWELL: begin
            dwell_we   = pt_ok && (r.wdata <= sscmd_pkg::TIME_MAX);
            next_r.err = !dwell_we;
          end
          sscmd_pkg::CMD_PT_AUX: begin
            aux_we     = pt_ok && (r.wdata <= sscmd_pkg::AUX_MAX);
            next_r.err = !aux_we;
          end
          default: begin
            next_r.err = 1'b1;
          end
        endcase
      end
      default: begin
      end
    endcase

    // A pulse in the clearing cycle is counted after the clear so it is not lost.
    fb_base = clr_fb ? 32'h0 : r.cum_fb;
    if (fb_pulse_i) begin
      next_r.cum_fb = fb_dir_i ? fb_base - 32'h1 : fb_base + 32'h1;
    end else begin
      next_r.cum_fb = fb_base;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r           <= '0;
      r.fsm       <= sscmd_pkg::SSCMD_IDLE;
      r.group     <= sscmd_pkg::GROUP_RESET;
      r.hready    <= 1'b1;
      r.hresp     <= sscmd_pkg::HRESP_OKAY;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 1; i <= NUM_POINTS; i++) begin
        acc_mem[i]   <= 16'h0;
        dec_mem[i]   <= 16'h0;
        dwell_mem[i] <= 16'h0;
        aux_mem[i]   <= 1'b0;
      end
      for (int j = 0; j < NUM_PARAMS; j++) begin
        par_ram[j] <= {3'h0, PARAM_RESET};
        par_eep[j] <= {3'h0, PARAM_RESET};
      end
    end else begin
      if (acc_we) begin
        acc_mem[pt_idx] <= r.wdata[15:0];
      end
      if (dec_we) begin
        dec_mem[pt_idx] <= r.wdata[15:0];
      end
      if (dwell_we) begin
        dwell_mem[pt_idx] <= r.wdata[15:0];
      end
      if (aux_we) begin
        aux_mem[pt_idx] <= r.wdata[0];
      end
      if (par_we) begin
        par_ram[par_idx] <= par_word;
      end
      if (eep_we) begin
        par_eep[par_idx] <= par_word;
      end
    end
  end

  assign hrdata_o    = r.hrdata;
  assign hreadyout_o = r.hready;
  assign hresp_o     = r.hresp;
  assign group_o     = r.group;
endmodule

// ---- hdl/sscmd_wcheck.sv ----
// Checks the header of a parameter write word: point position and write mode.
// Assumes the word is held stable by the caller while it is examined.
`timescale 1ns/1ps
module sscmd_wcheck (
  input  wire logic [31:0] wdata_i,
  input  wire logic        is_hex_i,
  output logic             ok_o,
  output logic             ram_only_o,
  output logic [26:0]      word_o
);
  logic [3:0] dp;
  logic [3:0] mode;

  always_comb begin
    dp   = wdata_i[sscmd_pkg::DP_MSB:sscmd_pkg::DP_LSB];
    mode = wdata_i[sscmd_pkg::MODE_MSB:sscmd_pkg::MODE_LSB];
    ok_o = 1'b1;
    if (dp > sscmd_pkg::DP_MAX) begin
      ok_o = 1'b0;
    end
    // Decimal data without a point position cannot be stored; hex data must carry zero.
    if (!is_hex_i && dp == sscmd_pkg::DP_NONE) begin
      ok_o = 1'b0;
    end
    if (is_hex_i && dp != sscmd_pkg::DP_NONE) begin
      ok_o = 1'b0;
    end
    if (mode != sscmd_pkg::MODE_EEP && mode != sscmd_pkg::MODE_RAM) begin
      ok_o = 1'b0;
    end
    ram_only_o = (mode == sscmd_pkg::MODE_RAM);
    word_o     = {dp[2:0], wdata_i[sscmd_pkg::VAL_MSB:0]};
  end
endmodule
